// ### hdl/pfw_pkg.sv
// Package for the program flash write control block.
// Assumes an Avalon-MM slave with 32-bit data, one register per word.
package pfw_pkg;
  // Register byte addresses
  localparam logic [5:0] ADDR_TBL_UPPER = 6'h00;
  localparam logic [5:0] ADDR_TBL_HIGH  = 6'h04;
  localparam logic [5:0] ADDR_TBL_LOW   = 6'h08;
  localparam logic [5:0] ADDR_TBL_LATCH = 6'h0C;
  localparam logic [5:0] ADDR_UNLOCK    = 6'h10;
  localparam logic [5:0] ADDR_WR_CTRL   = 6'h14;
  localparam logic [5:0] ADDR_IRQ_STAT  = 6'h18;
  localparam logic [5:0] ADDR_IRQ_MASK  = 6'h1C;
  localparam logic [5:0] ADDR_MEM_DATA  = 6'h20;
  localparam logic [5:0] ADDR_TBL_CMD   = 6'h24;
  // Control register bit positions
  localparam int CTL_RD    = 0;
  localparam int CTL_WR    = 1;
  localparam int CTL_MODIFY_PERMIT_BIT  = 2;
  localparam int CTL_ERR   = 3;
  localparam int CTL_ERASE = 4;
  localparam int CTL_CONFIG_SPACE_SELECT  = 6;
  localparam int CTL_PGD   = 7;
  localparam logic [7:0] CTL_MASK  = 8'hD7;
  localparam int UPPER_CFG = 5;
  localparam logic [7:0] UPPER_MASK = 8'h3F;
  // Table command bits: 0 read, 1 write, 2 post increment
  localparam int CMD_RD  = 0;
  localparam int CMD_WR  = 1;
  localparam int CMD_INC = 2;
  // Interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR  = 1;
  localparam logic [7:0] IRQ_MASK_BITS = 8'h03;
  // Unlock keys
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  // Timing
  localparam int CLK_HZ       = 25_000_000;
  localparam int ERASE_US     = 2;
  localparam int PROG_US      = 2;
  localparam int ERASE_CYCLES = ERASE_US * (CLK_HZ / 1_000_000);
  localparam int PROG_CYCLES  = PROG_US * (CLK_HZ / 1_000_000);
  localparam int BLOCK_BYTES  = 64;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ERASE = 2'b01,
    ST_PROG  = 2'b10
  } pfw_state_e;

  typedef struct packed {
    logic [5:0] address;
    logic       read;
    logic       write;
    logic [7:0] wdata;
  } pfw_req_s;
endpackage

// ### hdl/pfw_top.sv
// Program flash write control: table pointer, latch, unlock, write/erase.
// Assumes a synchronous Avalon-MM master and a memory array held inside.
// Overview of operation
// R1 - Write cut by master reset or watchdog sets the error flag.
// R2 - Software rereads and reprograms a location after any unplanned termination.
// R3 - Launch needs 55h then AAh unlock first; otherwise launch ignored.
// R4 - Pointer bit 21 steers table accesses to configuration space.
// R5 - Pointer formed from upper, high and low writable bytes.
// R6 - Eight-bit table latch carries each table read or write byte.
// R7 - Unlock port keeps no value; writes only feed the detector.
// R8 - Unimplemented register bits read as zero.
// R9 - Launch with erase select erases block and stalls CPU.
// R10 - Launch without erase select programs holding register and stalls CPU.
// R11 - Software sets erase select before launching an erase.
// R12 - Software keeps pointer inside the target 64-byte block before launch.
//
// Register access over Avalon-MM and the register offsets were decided locally.
module pfw_top #(
  parameter int DEPTH = 256,
  parameter int CFG_DEPTH = 16
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Reset cause inputs
  input  wire logic        external_master_reset,
  input  wire logic        watchdog_timeout,
  // Avalon-MM slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Status outputs
  output logic             cpu_stall,
  output logic             irq
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(CFG_DEPTH);

  // Cycle count, never below one
  function automatic logic [15:0] cyc16(input int n);
    cyc16 = (n < 1) ? 16'h0001 : n[15:0];
  endfunction

  // Byte address inside the pointer's 64-byte block
  function automatic logic [AW-1:0] blk_addr(input logic [21:0] p, input logic [5:0] off);
    blk_addr = AW'({p[21:6], off});
  endfunction

  pfw_pkg::pfw_req_s req;
  assign req = '{
    address: avs_address,
    read:    avs_read,
    write:   avs_write,
    wdata:   avs_writedata[7:0]
  };

  // Register state
  logic [7:0]          upper_r;
  logic [7:0]          upper_nxt;
  logic [7:0]          high_r;
  logic [7:0]          high_nxt;
  logic [7:0]          low_r;
  logic [7:0]          low_nxt;
  logic [7:0]          latch_r;
  logic [7:0]          latch_nxt;
  logic [7:0]          ctl_r;
  logic [7:0]          ctl_nxt;
  logic [7:0]          stat_r;
  logic [7:0]          stat_nxt;
  logic [7:0]          mask_r;
  logic [7:0]          mask_nxt;
  logic [1:0]          key_r;
  logic [1:0]          key_nxt;
  logic [15:0]         cnt_r;
  logic [15:0]         cnt_nxt;
  logic [5:0]          hcnt_r;
  logic [5:0]          hcnt_nxt;
  logic                ack_r;
  logic                ack_nxt;
  logic                stall_r;
  logic                stall_nxt;
  logic                irq_r;
  logic                irq_nxt;
  logic [31:0]         rdata_r;
  logic [31:0]         rdata_nxt;
  pfw_pkg::pfw_state_e st_r;
  pfw_pkg::pfw_state_e st_nxt;
  // Storage and its controls
  logic [7:0]          mem [DEPTH];
  logic [7:0]          cfg [CFG_DEPTH];
  logic [7:0]          hold [pfw_pkg::BLOCK_BYTES];
  logic [21:0]         tptr;
  logic                mem_we;
  logic                cfg_we;
  logic                hold_we;
  logic                clr_blk;
  logic [7:0]          mem_wd;
  logic [AW-1:0]       mem_wa;
  logic                acc;
  logic                wr_acc;
  logic                rd_acc;

  // R5 pointer assembly
  assign tptr   = {upper_r[5:0], high_r, low_r};
  assign acc    = (req.read | req.write) & ~ack_r;
  assign wr_acc = acc & req.write;
  assign rd_acc = acc & req.read;

  // Next state of registers, unlock and sequencer
  always_comb begin
    upper_nxt = upper_r;
    high_nxt  = high_r;
    low_nxt   = low_r;
    latch_nxt = latch_r;
    ctl_nxt   = ctl_r;
    stat_nxt  = stat_r;
    mask_nxt  = mask_r;
    key_nxt   = key_r;
    cnt_nxt   = cnt_r;
    hcnt_nxt  = hcnt_r;
    st_nxt    = st_r;
    ack_nxt   = 1'b0;
    rdata_nxt = rdata_r;
    mem_we    = 1'b0;
    cfg_we    = 1'b0;
    hold_we   = 1'b0;
    clr_blk   = 1'b0;
    mem_wd    = 8'h00;
    mem_wa    = '0;
    if (acc && st_r == pfw_pkg::ST_IDLE) begin
      ack_nxt = 1'b1;
      rdata_nxt = 32'h0000_0000;
      if (wr_acc) begin
        case (req.address)
          // R5 pointer bytes, R8 unused upper bits dropped
          pfw_pkg::ADDR_TBL_UPPER: upper_nxt = req.wdata & pfw_pkg::UPPER_MASK;
          pfw_pkg::ADDR_TBL_HIGH:  high_nxt = req.wdata;
          pfw_pkg::ADDR_TBL_LOW:   low_nxt = req.wdata;
          // R6 latch write
          pfw_pkg::ADDR_TBL_LATCH: latch_nxt = req.wdata;
          // R7 unlock detector only
          pfw_pkg::ADDR_UNLOCK: begin
            if (req.wdata == pfw_pkg::KEY_FIRST) key_nxt = 2'b01;
            else if (req.wdata == pfw_pkg::KEY_SECOND && key_r == 2'b01) key_nxt = 2'b10;
            else key_nxt = 2'b00;
          end
          pfw_pkg::ADDR_WR_CTRL: begin
            ctl_nxt = (req.wdata & pfw_pkg::CTL_MASK) & 8'hFC;
            ctl_nxt[pfw_pkg::CTL_ERR] = ctl_r[pfw_pkg::CTL_ERR] & req.wdata[pfw_pkg::CTL_ERR];
            key_nxt = 2'b00;
            // R3 launch only when unlocked and enabled
            if (req.wdata[pfw_pkg::CTL_WR] && key_r == 2'b10 &&
                req.wdata[pfw_pkg::CTL_MODIFY_PERMIT_BIT]) begin
              ctl_nxt[pfw_pkg::CTL_WR] = 1'b1;
              // Holding index restarts at each launch
              hcnt_nxt = 6'h00;
              // R9 erase, R10 program
              if (req.wdata[pfw_pkg::CTL_ERASE]) begin
                st_nxt  = pfw_pkg::ST_ERASE;
                cnt_nxt = cyc16(pfw_pkg::ERASE_CYCLES);
              end else begin
                st_nxt  = pfw_pkg::ST_PROG;
                cnt_nxt = cyc16(pfw_pkg::PROG_CYCLES);
              end
            end
          end
          pfw_pkg::ADDR_IRQ_STAT: stat_nxt = stat_r & ~req.wdata;
          pfw_pkg::ADDR_IRQ_MASK: mask_nxt = req.wdata & pfw_pkg::IRQ_MASK_BITS;
          pfw_pkg::ADDR_TBL_CMD: begin
            // R4 config space on bit 21, R6 latch transfer
            if (req.wdata[pfw_pkg::CMD_RD])
              latch_nxt = upper_r[pfw_pkg::UPPER_CFG] ? cfg[tptr[CW-1:0]] : mem[tptr[AW-1:0]];
            if (req.wdata[pfw_pkg::CMD_WR]) begin
              if (upper_r[pfw_pkg::UPPER_CFG]) cfg_we = 1'b1;
              else hold_we = 1'b1;
            end
            if (req.wdata[pfw_pkg::CMD_INC])
              {upper_nxt[5:0], high_nxt, low_nxt} = tptr + 22'h000001;
          end
          default: ;
        endcase
      end else if (rd_acc) begin
        case (req.address)
          // R8 zero-filled reads
          pfw_pkg::ADDR_TBL_UPPER: rdata_nxt[7:0] = upper_r;
          pfw_pkg::ADDR_TBL_HIGH:  rdata_nxt[7:0] = high_r;
          pfw_pkg::ADDR_TBL_LOW:   rdata_nxt[7:0] = low_r;
          pfw_pkg::ADDR_TBL_LATCH: rdata_nxt[7:0] = latch_r;
          pfw_pkg::ADDR_WR_CTRL:   rdata_nxt[7:0] = ctl_r;
          pfw_pkg::ADDR_IRQ_STAT:  rdata_nxt[7:0] = stat_r;
          pfw_pkg::ADDR_IRQ_MASK:  rdata_nxt[7:0] = mask_r;
          pfw_pkg::ADDR_MEM_DATA:  rdata_nxt[7:0] = mem[tptr[AW-1:0]];
          default: rdata_nxt = 32'h0000_0000;
        endcase
      end
    end
    case (st_r)
      pfw_pkg::ST_IDLE: ;
      pfw_pkg::ST_ERASE: begin
        clr_blk = (cnt_r == 16'h0001);
        if (cnt_r == 16'h0001) st_nxt = pfw_pkg::ST_IDLE;
        else cnt_nxt = cnt_r - 16'h0001;
      end
      pfw_pkg::ST_PROG: begin
        // R10 one holding byte per cycle, R12 block from pointer
        mem_we   = 1'b1;
        mem_wa   = blk_addr(tptr, hcnt_r);
        mem_wd   = hold[hcnt_r];
        hcnt_nxt = hcnt_r + 6'h01;
        if (cnt_r == 16'h0001 && hcnt_r == 6'h3F) st_nxt = pfw_pkg::ST_IDLE;
        else if (cnt_r != 16'h0001) cnt_nxt = cnt_r - 16'h0001;
      end
      default: st_nxt = pfw_pkg::ST_IDLE;
    endcase
    if (st_r != pfw_pkg::ST_IDLE && st_nxt == pfw_pkg::ST_IDLE) begin
      ctl_nxt[pfw_pkg::CTL_WR] = 1'b0;
      stat_nxt[pfw_pkg::IRQ_DONE] = 1'b1;
    end
    // R1 cut write flags error, set wins
    if ((external_master_reset | watchdog_timeout) && st_r != pfw_pkg::ST_IDLE) begin
      ctl_nxt[pfw_pkg::CTL_ERR] = 1'b1;
      ctl_nxt[pfw_pkg::CTL_WR]  = 1'b0;
      stat_nxt[pfw_pkg::IRQ_ERR] = 1'b1;
      st_nxt = pfw_pkg::ST_IDLE;
    end
    // R9 stall during operation
    stall_nxt = (st_nxt != pfw_pkg::ST_IDLE);
    irq_nxt   = |(stat_nxt & mask_nxt);
  end

  // Pointer and latch registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      upper_r <= 8'h00;
      high_r  <= 8'h00;
      low_r   <= 8'h00;
      latch_r <= 8'h00;
    end else begin
      upper_r <= upper_nxt;
      high_r  <= high_nxt;
      low_r   <= low_nxt;
      latch_r <= latch_nxt;
    end
  end

  // Control, unlock and interrupt registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctl_r   <= {ctl_r[7:4], ctl_r[pfw_pkg::CTL_ERR], 3'h0} & 8'h08;
      stat_r  <= 8'h00;
      mask_r  <= 8'h00;
      key_r   <= 2'b00;
      irq_r   <= 1'b0;
    end else begin
      ctl_r   <= ctl_nxt;
      stat_r  <= stat_nxt;
      mask_r  <= mask_nxt;
      key_r   <= key_nxt;
      irq_r   <= irq_nxt;
    end
  end

  // Sequencer registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_r   <= 16'h0000;
      hcnt_r  <= 6'h00;
      st_r    <= pfw_pkg::ST_IDLE;
      stall_r <= 1'b0;
    end else begin
      cnt_r   <= cnt_nxt;
      hcnt_r  <= hcnt_nxt;
      st_r    <= st_nxt;
      stall_r <= stall_nxt;
    end
  end

  // Bus response registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r   <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Storage arrays, no reset
  always_ff @(posedge clk_sys) begin
    if (hold_we) hold[tptr[5:0]] <= latch_r;
    if (cfg_we) cfg[tptr[CW-1:0]] <= latch_r;
    if (mem_we) mem[mem_wa] <= mem_wd;
    if (clr_blk) begin
      for (int i = 0; i < pfw_pkg::BLOCK_BYTES; i++) begin
        mem[blk_addr(tptr, 6'(i))] <= 8'hFF;
      end
    end
  end

  // Ports straight from registers
  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = ~ack_r;
  assign cpu_stall       = stall_r;
  assign irq             = irq_r;
endmodule // pfw_top

// ### testbench/pfw_asserts.sv
// Assertions on the pfw_top ports, bound into every instance.
// Assumes the offsets and unlock keys of pfw_pkg.
module pfw_asserts (
  // Clock, reset and reset causes
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        external_master_reset,
  input wire logic        watchdog_timeout,
  // Register bus and status
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        cpu_stall,
  input wire logic        irq
);
  logic       k1_r, k2_r, ab_r, k1_nxt, k2_nxt, ab_nxt, wa, cw;
  logic [1:0] mk_r, mk_nxt;
  logic [9:0] cn_r, cn_nxt;
  assign wa = avs_write && !avs_waitrequest;
  assign cw = wa && avs_address == pfw_pkg::ADDR_WR_CTRL;
  // Unlock state, mask copy, stall length
  always_comb begin
    k1_nxt = cw ? 1'h0 : k1_r;
    k2_nxt = cw ? 1'h0 : k2_r;
    mk_nxt = (wa && avs_address == pfw_pkg::ADDR_IRQ_MASK) ? avs_writedata[1:0] : mk_r;
    cn_nxt = cpu_stall ? cn_r + 10'h001 : 10'h000;
    ab_nxt = cpu_stall && (ab_r || watchdog_timeout || external_master_reset);
    if (wa && avs_address == pfw_pkg::ADDR_UNLOCK) begin
      k1_nxt = avs_writedata[7:0] == pfw_pkg::KEY_FIRST;
      k2_nxt = k1_r && avs_writedata[7:0] == pfw_pkg::KEY_SECOND;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      {k1_r, k2_r, ab_r, mk_r, cn_r} <= '0;
    end else begin
      {k1_r, k2_r, ab_r, mk_r, cn_r} <= {k1_nxt, k2_nxt, ab_nxt, mk_nxt, cn_nxt};
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low two cycles");
  chk_reset_quiet: assert property (disable iff (1'h0) sys_rst |=> avs_waitrequest && !cpu_stall)
    else $error("activity during reset");
  chk_launch_refused: assert property (cw && !k2_r |=> !cpu_stall [*3])
    else $error("launch without unlock ran");
  chk_launch_runs: assert property (cw && k2_r && avs_writedata[2:1] == 2'h3 |-> ##[1:3] cpu_stall)
    else $error("unlocked launch did not stall");
  chk_stall_min: assert property ($fell(cpu_stall) && !ab_r |-> cn_r >= 10'd48)
    else $error("stall too short");
  chk_done_irq: assert property ($fell(cpu_stall) && mk_r[0] && !ab_r |-> ##[0:2] irq)
    else $error("no done interrupt");
  chk_err_irq: assert property (cpu_stall && mk_r[1] && (watchdog_timeout || external_master_reset)
    |-> ##[1:3] irq)
    else $error("no error interrupt");
  chk_stall_hold: assert property (cpu_stall && $past(cpu_stall) |-> avs_waitrequest)
    else $error("access served while stalled");
  chk_unlock_zero: assert property (avs_read && !avs_waitrequest
    && avs_address == pfw_pkg::ADDR_UNLOCK |-> avs_readdata == 32'h0)
    else $error("unlock port read not zero");
  cover property ($rose(cpu_stall));
  cover property (cw && !k2_r);
  cover property ($rose(irq));
endmodule // pfw_asserts

bind pfw_top pfw_asserts u_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .external_master_reset(external_master_reset),
  .watchdog_timeout(watchdog_timeout), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .cpu_stall(cpu_stall), .irq(irq)
);

// ### testbench/program_flash_write_control_test.sv
// Self-checking bench: drives pfw_top over Avalon-MM, checks readback.
// Assumes the register map and bit layout of pfw_pkg.
module program_flash_write_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'h0;
  logic        sys_rst = 1'h1;
  logic        external_master_reset = 1'h0;
  logic        watchdog_timeout = 1'h0;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'h0;
  logic        avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest, cpu_stall, irq;
  logic [21:0] note_q[$];
  logic [21:0] nt;
  logic [7:0]  r;
  int          fails = 0;
  int          check_count = 0;
  int          cyc = 0;

  always #20 clk_sys = ~clk_sys;

  pfw_top dut_u (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .external_master_reset(external_master_reset),
    .watchdog_timeout(watchdog_timeout), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cpu_stall(cpu_stall), .irq(irq)
  );

  task automatic conclude;
    if (fails == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic bus(input logic [5:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h000000, d};
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wrd(input logic [5:0] a, input logic [7:0] d, e, m);
    bus(a, 1'b1, d);
    note_q.push_back({a, m, e});
    bus(a, 1'b0, 8'h00);
  endtask

  task automatic go(input logic [7:0] d, e, s);
    bus(pfw_pkg::ADDR_UNLOCK, 1'b1, pfw_pkg::KEY_FIRST);
    bus(pfw_pkg::ADDR_UNLOCK, 1'b1, pfw_pkg::KEY_SECOND);
    wrd(pfw_pkg::ADDR_WR_CTRL, d, e, 8'hFF);
    note_q.push_back({pfw_pkg::ADDR_IRQ_STAT, 8'h03, s});
    bus(pfw_pkg::ADDR_IRQ_STAT, 1'b0, 8'h00);
    bus(pfw_pkg::ADDR_IRQ_STAT, 1'b1, 8'h03);
  endtask

  task automatic cmp(input logic [5:0] a, input logic [7:0] m, input logic [31:0] e, s);
    check_count++;
    if ((s & {24'hFFFFFF, m}) !== e) begin
      fails++;
      $display("unexpected readdata at %h: expected %h seen %h", a, e, s);
    end
  endtask

  // Watcher: pairs each completed read with the oldest note
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      conclude;
    end
    if (avs_read && avs_waitrequest === 1'b0) begin
      nt = note_q.pop_front();
      cmp(nt[21:16], nt[15:8], {24'h000000, nt[7:0]}, avs_readdata);
    end
  end

  initial begin
    void'($urandom(58668));
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    r = 8'($urandom);
    wrd(pfw_pkg::ADDR_TBL_UPPER, 8'hFF, 8'h3F, 8'hFF);
    wrd(pfw_pkg::ADDR_TBL_HIGH, r, r, 8'hFF);
    wrd(pfw_pkg::ADDR_TBL_LOW, ~r, ~r, 8'hFF);
    wrd(pfw_pkg::ADDR_TBL_LATCH, r ^ 8'hA5, r ^ 8'hA5, 8'hFF);
    wrd(pfw_pkg::ADDR_UNLOCK, pfw_pkg::KEY_FIRST, 8'h00, 8'hFF);
    wrd(6'h28, r, 8'h00, 8'hFF);
    wrd(pfw_pkg::ADDR_IRQ_MASK, 8'h03, 8'h03, 8'hFF);
    wrd(pfw_pkg::ADDR_WR_CTRL, 8'h86, 8'h84, 8'hFF);
    go(8'h96, 8'h94, 8'h01);
    go(8'h86, 8'h84, 8'h01);
    for (int i = 0; i < 2; i++) begin
      bus(pfw_pkg::ADDR_UNLOCK, 1'b1, pfw_pkg::KEY_FIRST);
      bus(pfw_pkg::ADDR_UNLOCK, 1'b1, pfw_pkg::KEY_SECOND);
      bus(pfw_pkg::ADDR_WR_CTRL, 1'b1, 8'h86);
      repeat (8) if (cpu_stall !== 1'b1) @(posedge clk_sys);
      {external_master_reset, watchdog_timeout} <= i[0] ? 2'h2 : 2'h1;
      @(posedge clk_sys);
      {external_master_reset, watchdog_timeout} <= 2'h0;
      wrd(pfw_pkg::ADDR_IRQ_MASK, 8'h03, 8'h03, 8'hFF);
      go(8'h08, 8'h08, 8'h02);
    end
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    wrd(pfw_pkg::ADDR_TBL_UPPER, 8'h20, 8'h20, 8'hFF);
    note_q.push_back({pfw_pkg::ADDR_WR_CTRL, 8'h08, 8'h08});
    bus(pfw_pkg::ADDR_WR_CTRL, 1'b0, 8'h00);
    wrd(pfw_pkg::ADDR_WR_CTRL, 8'h00, 8'h00, 8'hFF);
    bus(pfw_pkg::ADDR_TBL_LATCH, 1'b1, r ^ 8'h3C);
    bus(pfw_pkg::ADDR_TBL_CMD, 1'b1, 8'h02);
    wrd(pfw_pkg::ADDR_TBL_LATCH, 8'h00, 8'h00, 8'hFF);
    bus(pfw_pkg::ADDR_TBL_CMD, 1'b1, 8'h01);
    note_q.push_back({pfw_pkg::ADDR_TBL_LATCH, 8'hFF, r ^ 8'h3C});
    bus(pfw_pkg::ADDR_TBL_LATCH, 1'b0, 8'h00);
    wrd(pfw_pkg::ADDR_TBL_UPPER, 8'h00, 8'h00, 8'hFF);
    bus(pfw_pkg::ADDR_TBL_CMD, 1'b1, 8'h02);
    go(8'h86, 8'h84, 8'h01);
    note_q.push_back({pfw_pkg::ADDR_MEM_DATA, 8'hFF, r ^ 8'h3C});
    bus(pfw_pkg::ADDR_MEM_DATA, 1'b0, 8'h00);
    conclude;
  end
endmodule // program_flash_write_control_test
